// ===== ssp_defs.vh
// constants for the synchronous serial port: offsets, bit positions, reset values, counts
// assumes inclusion by bare name from the fifo and top design files of the port
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH

// --------------------------------
// register offsets
// --------------------------------
`define SSP_OFS_CTRL 12'h004
`define SSP_OFS_DATA 12'h008
`define SSP_OFS_STAT 12'h00C
`define SSP_OFS_CPSR 12'h010
`define SSP_OFS_MASK 12'h014
`define SSP_OFS_RAW 12'h018
`define SSP_OFS_MIS 12'h01C
`define SSP_OFS_ICR 12'h020

// --------------------------------
// field positions
// --------------------------------
`define SSP_BIT_LOOP 0
`define SSP_BIT_BUSY 4
`define SSP_BIT_RFF 3
`define SSP_BIT_RNE 2
`define SSP_BIT_TNF 1
`define SSP_BIT_TFE 0
`define SSP_BIT_TXI 3
`define SSP_BIT_RXI 2
`define SSP_BIT_RTI 1
`define SSP_BIT_ROR 0

// --------------------------------
// reset values and counts
// --------------------------------
`define SSP_RST_CPSR 8'h00
`define SSP_RST_MASK 4'h0
`define SSP_CPSR_KEEP 8'hFE
`define SSP_FIFO_DEPTH 8
`define SSP_FIFO_AW 3
`define SSP_FIFO_HALF 4'h4
`define SSP_FIFO_FULL 4'h8
`define SSP_CMD_TX_BITS 5'h08
`define SSP_FMT_CMD 2'h2
`define SSP_TO_HALF_TICKS 7'h40

`endif

// ===== ssp_sync.v
// three-stage synchroniser for one pin input with agreement filter
// assumes the pin is asynchronous to i_clk
`default_nettype none

module ssp_sync (
	input wire i_clk,
	input wire i_rst,
	input wire i_pin,
	output reg o_level
);

	reg s1_r;
	reg s2_r;
	reg s3_r;

	// first stage feeds only the second; change taken once stages two and three agree
	always @(posedge i_clk) begin
		if (i_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			o_level <= 1'b0;
		end else begin
			s1_r <= i_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				o_level <= s3_r;
			end
		end
	end

endmodule

`default_nettype wire

// ===== ssp_fifo.v
// 16-bit wide, eight-entry first-in first-out store
// assumes the caller never pushes when full nor pops when empty; such requests are dropped
`default_nettype none
`include "ssp_defs.vh"

module ssp_fifo (
	input wire i_clk,
	input wire i_rst,
	input wire i_push,
	input wire [15:0] i_wdata,
	input wire i_pop,
	output wire [15:0] o_head,
	output reg [3:0] o_count
);

	reg [15:0] mem_r [0:`SSP_FIFO_DEPTH-1];
	reg [`SSP_FIFO_AW-1:0] wptr_r;
	reg [`SSP_FIFO_AW-1:0] rptr_r;
	wire do_push;
	wire do_pop;

	assign do_push = i_push && (o_count != `SSP_FIFO_FULL);
	assign do_pop = i_pop && (o_count != 4'h0);
	assign o_head = mem_r[rptr_r];

	// storage has no reset; only pointers and count are control state
	always @(posedge i_clk) begin
		if (do_push) begin
			mem_r[wptr_r] <= i_wdata;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			wptr_r <= {`SSP_FIFO_AW{1'b0}};
			rptr_r <= {`SSP_FIFO_AW{1'b0}};
			o_count <= 4'h0;
		end else begin
			if (do_push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (do_pop) begin
				rptr_r <= rptr_r + 1'b1;
			end
			if (do_push && !do_pop) begin
				o_count <= o_count + 4'h1;
			end else if (do_pop && !do_push) begin
				o_count <= o_count - 4'h1;
			end
		end
	end

endmodule

`default_nettype wire

// ===== ssp_top.v
// synchronous serial port: data, status, prescale and interrupt registers plus the shift engine
// assumes a register master with one-cycle strobes; format, size, rate and role come in as levels
`default_nettype none
`include "ssp_defs.vh"

module ssp_top (
	input wire i_ref_clk,
	input wire i_rst,
	input wire [11:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	input wire i_port_en,
	input wire i_master,
	input wire [1:0] i_frame_fmt,
	input wire [3:0] i_data_size,
	input wire [7:0] i_scr,
	input wire i_slave_out_dis,
	input wire i_sclk,
	input wire i_fss_n,
	input wire i_rxd,
	output reg o_sclk,
	output reg o_fss_n,
	output reg o_txd,
	output reg o_txd_oe,
	output reg o_irq
);

	// --------------------------------
	// pin synchronisers
	// --------------------------------
	wire [2:0] pin_raw;
	wire [2:0] pin_s;
	wire sclk_s;
	wire fss_n_s;
	wire rxd_s;

	assign pin_raw = {i_sclk, i_fss_n, i_rxd};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			ssp_sync u_sync (
				.i_clk(i_ref_clk),
				.i_rst(i_rst),
				.i_pin(pin_raw[gi]),
				.o_level(pin_s[gi])
			);
		end
	endgenerate

	assign sclk_s = pin_s[2];
	assign fss_n_s = pin_s[1];
	assign rxd_s = pin_s[0];

	// --------------------------------
	// register decode
	// --------------------------------
	reg loop_r;
	reg [7:0] cpsr_r;
	reg [3:0] mask_r;
	reg ror_r;
	reg rto_r;

	wire wr_ctrl;
	wire wr_data;
	wire wr_cpsr;
	wire wr_mask;
	wire wr_icr;
	wire rd_data;

	assign wr_ctrl = i_wr && (i_addr == `SSP_OFS_CTRL);
	assign wr_data = i_wr && (i_addr == `SSP_OFS_DATA);
	assign wr_cpsr = i_wr && (i_addr == `SSP_OFS_CPSR);
	assign wr_mask = i_wr && (i_addr == `SSP_OFS_MASK);
	assign wr_icr = i_wr && (i_addr == `SSP_OFS_ICR);
	assign rd_data = i_rd && (i_addr == `SSP_OFS_DATA);

	// --------------------------------
	// fifos
	// --------------------------------
	wire [15:0] tx_head;
	wire [3:0] tx_count;
	wire [15:0] rx_head;
	wire [3:0] rx_count;
	wire tx_empty;
	wire tx_full;
	wire rx_empty;
	wire rx_full;
	reg rx_valid_r;
	reg [15:0] rx_word_r;
	reg tx_take_r;
	wire rx_push;
	wire rx_pop;

	assign tx_empty = (tx_count == 4'h0);
	assign tx_full = (tx_count == `SSP_FIFO_FULL);
	assign rx_empty = (rx_count == 4'h0);
	assign rx_full = (rx_count == `SSP_FIFO_FULL);
	assign rx_push = rx_valid_r && !rx_full;
	assign rx_pop = rd_data && !rx_empty;

	// fifos ignore the port enable so software can preload before enabling
	ssp_fifo u_txf (
		.i_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_push(wr_data),
		.i_wdata(i_wdata[15:0]),
		.i_pop(tx_take_r),
		.o_head(tx_head),
		.o_count(tx_count)
	);

	ssp_fifo u_rxf (
		.i_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_push(rx_push),
		.i_wdata(rx_word_r),
		.i_pop(rx_pop),
		.o_head(rx_head),
		.o_count(rx_count)
	);

	// --------------------------------
	// prescaler
	// --------------------------------
	reg [6:0] precnt_r;
	reg half_tick_r;
	wire [6:0] pre_half;

	// half of the even divisor gives a tick per half prescaled clock
	assign pre_half = (cpsr_r[7:1] == 7'h00) ? 7'h01 : cpsr_r[7:1];

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			precnt_r <= 7'h00;
			half_tick_r <= 1'b0;
		end else if (!i_port_en) begin
			precnt_r <= 7'h00;
			half_tick_r <= 1'b0;
		end else if (precnt_r + 7'h01 >= pre_half) begin
			precnt_r <= 7'h00;
			half_tick_r <= 1'b1;
		end else begin
			precnt_r <= precnt_r + 7'h01;
			half_tick_r <= 1'b0;
		end
	end

	// --------------------------------
	// shift engine
	// --------------------------------
	reg active_r;
	reg [15:0] sh_tx_r;
	reg [15:0] sh_rx_r;
	reg [4:0] bitcnt_r;
	reg [4:0] flen_r;
	reg [4:0] rxbits_r;
	reg [7:0] scrcnt_r;
	reg sclk_d_r;

	wire cmd_fmt;
	wire [4:0] rx_bits;
	wire [4:0] tx_bits;
	wire [4:0] frame_len;
	wire [15:0] tx_src;
	wire [15:0] load_w;
	wire [15:0] rx_mask;
	wire rx_bit;
	wire start_m;
	wire start_s;
	wire s_rise;
	wire s_fall;
	wire m_edge;
	wire sample;
	wire shift;
	wire last_bit;

	assign cmd_fmt = (i_frame_fmt == `SSP_FMT_CMD);
	assign rx_bits = {1'b0, i_data_size} + 5'h01;
	assign tx_bits = cmd_fmt ? `SSP_CMD_TX_BITS : rx_bits;
	// command frames send the command byte, then clock in the reply
	assign frame_len = cmd_fmt ? (`SSP_CMD_TX_BITS + rx_bits) : rx_bits;
	// slave with nothing queued sends zeros
	assign tx_src = tx_empty ? 16'h0000 : tx_head;
	// left-justify so upper unused bits never reach the pin
	assign load_w = tx_src << (5'h10 - tx_bits);
	assign rx_mask = 16'hFFFF >> (5'h10 - rxbits_r);
	assign rx_bit = loop_r ? o_txd : rxd_s;

	assign start_m = !active_r && i_port_en && i_master && !tx_empty;
	assign start_s = !active_r && i_port_en && !i_master && !fss_n_s;
	assign s_rise = sclk_s && !sclk_d_r;
	assign s_fall = !sclk_s && sclk_d_r;
	assign m_edge = half_tick_r && (scrcnt_r == i_scr);
	assign sample = active_r && (i_master ? (m_edge && !o_sclk) : s_rise);
	assign shift = active_r && (i_master ? (m_edge && o_sclk) : s_fall);
	assign last_bit = (bitcnt_r + 5'h01 == flen_r);

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			active_r <= 1'b0;
			sh_tx_r <= 16'h0000;
			sh_rx_r <= 16'h0000;
			bitcnt_r <= 5'h00;
			flen_r <= 5'h00;
			rxbits_r <= 5'h10;
			scrcnt_r <= 8'h00;
			sclk_d_r <= 1'b0;
			tx_take_r <= 1'b0;
			rx_valid_r <= 1'b0;
			rx_word_r <= 16'h0000;
			o_sclk <= 1'b0;
			o_fss_n <= 1'b1;
			o_txd <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
			tx_take_r <= 1'b0;
			rx_valid_r <= 1'b0;
			if (start_m || start_s) begin
				active_r <= 1'b1;
				sh_tx_r <= load_w;
				o_txd <= load_w[15];
				bitcnt_r <= 5'h00;
				flen_r <= frame_len;
				rxbits_r <= rx_bits;
				scrcnt_r <= 8'h00;
				tx_take_r <= !tx_empty;
				o_fss_n <= !i_master;
			end else if (active_r && (!i_port_en || (!i_master && fss_n_s))) begin
				// abandoned frame: nothing is stored
				active_r <= 1'b0;
				o_sclk <= 1'b0;
				o_fss_n <= 1'b1;
			end else if (active_r) begin
				if (half_tick_r) begin
					scrcnt_r <= (scrcnt_r == i_scr) ? 8'h00 : scrcnt_r + 8'h01;
				end
				if (i_master && m_edge) begin
					o_sclk <= !o_sclk;
				end
				if (sample) begin
					sh_rx_r <= {sh_rx_r[14:0], rx_bit};
				end
				if (shift) begin
					sh_tx_r <= {sh_tx_r[14:0], 1'b0};
					o_txd <= sh_tx_r[14];
					bitcnt_r <= bitcnt_r + 5'h01;
					if (last_bit) begin
						active_r <= 1'b0;
						o_fss_n <= 1'b1;
						rx_valid_r <= 1'b1;
						rx_word_r <= sh_rx_r & rx_mask;
					end
				end
			end else begin
				o_sclk <= 1'b0;
				o_fss_n <= 1'b1;
			end
		end
	end

	// --------------------------------
	// control, prescale, mask registers
	// --------------------------------
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			loop_r <= 1'b0;
			cpsr_r <= `SSP_RST_CPSR;
			mask_r <= `SSP_RST_MASK;
		end else begin
			if (wr_ctrl) begin
				loop_r <= i_wdata[`SSP_BIT_LOOP];
			end
			if (wr_cpsr) begin
				cpsr_r <= i_wdata[7:0] & `SSP_CPSR_KEEP;
			end
			if (wr_mask) begin
				mask_r <= i_wdata[3:0];
			end
		end
	end

	// --------------------------------
	// latched interrupt conditions
	// --------------------------------
	reg [6:0] tocnt_r;
	wire to_hit;

	// timeout counts prescaled half ticks while rx data sits unread
	assign to_hit = half_tick_r && (tocnt_r == `SSP_TO_HALF_TICKS - 7'h01);

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			tocnt_r <= 7'h00;
		end else if (rx_empty || rx_valid_r || rx_pop || active_r) begin
			tocnt_r <= 7'h00;
		end else if (half_tick_r && (tocnt_r != `SSP_TO_HALF_TICKS)) begin
			tocnt_r <= tocnt_r + 7'h01;
		end
	end

	// set wins over a clear in the same cycle
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			ror_r <= 1'b0;
			rto_r <= 1'b0;
		end else begin
			if (rx_valid_r && rx_full) begin
				ror_r <= 1'b1;
			end else if (wr_icr && i_wdata[`SSP_BIT_ROR]) begin
				ror_r <= 1'b0;
			end
			if (to_hit) begin
				rto_r <= 1'b1;
			end else if (wr_icr && i_wdata[`SSP_BIT_RTI]) begin
				rto_r <= 1'b0;
			end
		end
	end

	// --------------------------------
	// status and read data
	// --------------------------------
	wire [3:0] raw;
	wire [3:0] masked;
	wire busy;
	reg [31:0] rd_nxt;

	assign raw[`SSP_BIT_TXI] = (tx_count <= `SSP_FIFO_HALF);
	assign raw[`SSP_BIT_RXI] = (rx_count >= `SSP_FIFO_HALF);
	assign raw[`SSP_BIT_RTI] = rto_r;
	assign raw[`SSP_BIT_ROR] = ror_r;
	assign masked = raw & mask_r;
	assign busy = active_r || !tx_empty;

	always @* begin
		rd_nxt = 32'h00000000;
		case (i_addr)
			`SSP_OFS_CTRL: begin
				rd_nxt[`SSP_BIT_LOOP] = loop_r;
			end
			`SSP_OFS_DATA: begin
				rd_nxt[15:0] = rx_empty ? 16'h0000 : rx_head;
			end
			`SSP_OFS_STAT: begin
				rd_nxt[`SSP_BIT_BUSY] = busy;
				rd_nxt[`SSP_BIT_RFF] = rx_full;
				rd_nxt[`SSP_BIT_RNE] = !rx_empty;
				rd_nxt[`SSP_BIT_TNF] = !tx_full;
				rd_nxt[`SSP_BIT_TFE] = tx_empty;
			end
			`SSP_OFS_CPSR: begin
				rd_nxt[7:0] = cpsr_r;
			end
			`SSP_OFS_MASK: begin
				rd_nxt[3:0] = mask_r;
			end
			`SSP_OFS_RAW: begin
				rd_nxt[3:0] = raw;
			end
			`SSP_OFS_MIS: begin
				rd_nxt[3:0] = masked;
			end
			default: begin
				rd_nxt = 32'h00000000;
			end
		endcase
	end

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h00000000;
			o_irq <= 1'b0;
			o_txd_oe <= 1'b0;
		end else begin
			o_rdata <= i_rd ? rd_nxt : 32'h00000000;
			o_irq <= |masked;
			// a slave told to keep quiet never drives the line
			o_txd_oe <= i_port_en && (i_master || (!i_slave_out_dis && !fss_n_s));
		end
	end

endmodule

`default_nettype wire

// ===== ssp_top_assertions.sv
// checker for the serial port register bus and link pins
// assumes bind onto ssp_top, one clock, master role on the link
`default_nettype none
`include "ssp_defs.vh"

module ssp_top_assertions (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_sclk,
	input wire logic o_fss_n,
	input wire logic o_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------
	// checks
	// ----------------
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	data_width_a: assert property ($past(i_rd) && $past(i_addr) == `SSP_OFS_DATA |-> o_rdata[31:16] == 16'h0)
		else $error("data read has upper bits set");
	flag_pairs_a: assert property ($past(i_rd) && $past(i_addr) == `SSP_OFS_STAT |->
		(o_rdata[0] -> o_rdata[1]) && (o_rdata[3] -> o_rdata[2]) && o_rdata[31:5] == 27'h0)
		else $error("status flags inconsistent");
	busy_tx_a: assert property ($past(i_rd) && $past(i_addr) == `SSP_OFS_STAT && !o_rdata[0] |-> o_rdata[4])
		else $error("busy low while tx fifo holds data");
	mask_back_a: assert property (i_wr && i_addr == `SSP_OFS_MASK ##1 i_rd && i_addr == `SSP_OFS_MASK
		|=> o_rdata == {28'h0, $past(i_wdata[3:0], 2)})
		else $error("mask readback wrong");
	cpsr_back_a: assert property (i_wr && i_addr == `SSP_OFS_CPSR ##1 i_rd && i_addr == `SSP_OFS_CPSR
		|=> o_rdata[7:0] == ($past(i_wdata[7:0], 2) & 8'hFE) && o_rdata[31:8] == 24'h0)
		else $error("prescale readback wrong");
	irq_mis_a: assert property ($past(i_rd) && $past(i_addr) == `SSP_OFS_MIS |->
		o_irq == (|o_rdata[3:0]) && o_rdata[31:4] == 28'h0)
		else $error("irq does not match masked status");
	sclk_idle_a: assert property (o_fss_n |-> !o_sclk)
		else $error("serial clock moves outside frame");
	frame_c: cover property ($fell(o_fss_n));
	irq_c: cover property ($rose(o_irq));
	rx_c: cover property ($past(i_rd) && $past(i_addr) == `SSP_OFS_DATA && o_rdata != 32'h0);
endmodule

bind ssp_top ssp_top_assertions i_chk (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.o_sclk, .o_fss_n, .o_irq);
`default_nettype wire

// ===== ssp_peer.sv
// serial peripheral facing the port in master role
// assumes mode 0: sample on clock rise, shift on fall
`default_nettype none

module ssp_peer #(parameter logic [15:0] REPLY = 16'h00C3) (
	input wire logic i_sclk,
	input wire logic i_fss_n,
	input wire logic i_txd,
	output var logic o_rxd,
	output var logic [15:0] o_cap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] sh_r;
	initial begin
		o_rxd = 1'b1;
		o_cap = 16'h0;
		sh_r = REPLY;
	end
	always @(negedge i_fss_n) begin
		sh_r = REPLY;
		o_rxd = REPLY[15];
		o_cap = 16'h0;
	end
	// released line: show inverse so a late sample is caught
	always @(posedge i_fss_n) o_rxd = ~o_rxd;
	always @(posedge i_sclk) if (!i_fss_n) o_cap = {o_cap[14:0], i_txd};
	always @(negedge i_sclk) if (!i_fss_n) begin
		sh_r = {sh_r[14:0], 1'b0};
		o_rxd = sh_r[15];
	end
endmodule
`default_nettype wire

// ===== ssp_top_test.sv
// self-checking bench for the serial port block
// assumes ssp_top, ssp_peer and the checker bind compiled first
`default_nettype none
`include "ssp_defs.vh"

module ssp_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic en = 1'b0;
	logic [1:0] fmt = 2'h0;
	logic [3:0] dsz = 4'h7;
	logic [7:0] scr = 8'h00;
	logic [31:0] rdata;
	logic [31:0] v;
	logic [15:0] cap;
	logic sclk, fss_n, txd, rxd, irq;
	int fail_count = 0;
	int total_checks = 0;
	always #20 clk = ~clk;
	ssp_top i_ssp_top (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_port_en(en), .i_master(1'b1), .i_frame_fmt(fmt), .i_data_size(dsz), .i_scr(scr),
		.i_slave_out_dis(1'b0), .i_sclk(1'b0), .i_fss_n(1'b1), .i_rxd(rxd), .o_sclk(sclk), .o_fss_n(fss_n),
		.o_txd(txd), .o_txd_oe(), .o_irq(irq));
	ssp_peer i_ssp_peer (.i_sclk(sclk), .i_fss_n(fss_n), .i_txd(txd), .o_rxd(rxd), .o_cap(cap));
	// ----------------
	// bus helpers
	// ----------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
		check(v, e);
	endtask
	task automatic wait_idle;
		// polls the busy bit; a port that never goes idle counts as a mismatch
		for (int n = 0; n < 400; n++) begin
			addr <= `SSP_OFS_STAT;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 v = rdata;
			if (v[4] === 1'b0) break;
		end
		check({31'h0, v[4]}, 32'h0);
		// push lands a cycle after the frame ends
		repeat (4) @(posedge clk);
		#1;
	endtask
	// ----------------
	// scenarios
	// ----------------
	task automatic t_reset;
		rchk(`SSP_OFS_STAT, 32'h3);
		rchk(`SSP_OFS_RAW, 32'h8);
		rchk(`SSP_OFS_MASK, 32'h0);
		rchk(`SSP_OFS_MIS, 32'h0);
		rchk(`SSP_OFS_CPSR, 32'h0);
		rchk(12'h024, 32'h0);
		rchk(`SSP_OFS_DATA, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_regs;
		wreg(`SSP_OFS_MASK, 32'hFFFF_FFF8);
		rchk(`SSP_OFS_MASK, 32'h8);
		wreg(`SSP_OFS_RAW, 32'h0);
		rchk(`SSP_OFS_RAW, 32'h8);
		wreg(`SSP_OFS_MIS, 32'h0);
		rchk(`SSP_OFS_MIS, 32'h8);
		check({31'h0, irq}, 32'h1);
		wreg(`SSP_OFS_MASK, 32'h7);
		rchk(`SSP_OFS_MIS, 32'h0);
		check({31'h0, irq}, 32'h0);
		wreg(`SSP_OFS_CPSR, 32'h0000_0107);
		rchk(`SSP_OFS_CPSR, 32'h6);
		$display("register test done");
	endtask
	task automatic t_loop;
		wreg(`SSP_OFS_CTRL, 32'h1);
		wreg(`SSP_OFS_CPSR, 32'h2);
		wreg(`SSP_OFS_DATA, 32'h01A5);
		wreg(`SSP_OFS_DATA, 32'h003C);
		rchk(`SSP_OFS_STAT, 32'h12);
		en <= 1'b1;
		wait_idle;
		rchk(`SSP_OFS_DATA, 32'hA5);
		rchk(`SSP_OFS_DATA, 32'h3C);
		rchk(`SSP_OFS_STAT, 32'h3);
		en <= 1'b0;
		$display("loopback test done");
	endtask
	task automatic t_ovr;
		for (int i = 0; i < 8; i++) wreg(`SSP_OFS_DATA, 32'h10 + i);
		rchk(`SSP_OFS_STAT, 32'h10);
		en <= 1'b1;
		wait_idle;
		rchk(`SSP_OFS_STAT, 32'hF);
		wreg(`SSP_OFS_DATA, 32'h99);
		wait_idle;
		repeat (200) @(posedge clk);
		#1;
		rchk(`SSP_OFS_RAW, 32'hF);
		en <= 1'b0;
		wreg(`SSP_OFS_ICR, 32'h3);
		rchk(`SSP_OFS_RAW, 32'hC);
		for (int i = 0; i < 8; i++) rchk(`SSP_OFS_DATA, 32'h10 + i);
		rchk(`SSP_OFS_RAW, 32'h8);
		$display("overrun test done");
	endtask
	task automatic t_cmd;
		int n;
		wreg(`SSP_OFS_CTRL, 32'h0);
		wreg(`SSP_OFS_CPSR, 32'h4);
		fmt <= `SSP_FMT_CMD;
		// half period of six cycles leaves room for the four-cycle pin synchroniser
		scr <= 8'h02;
		wreg(`SSP_OFS_DATA, 32'h7E5A);
		en <= 1'b1;
		@(posedge sclk);
		n = 0;
		while (sclk === 1'b1) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(n, 32'h6);
		wait_idle;
		rchk(`SSP_OFS_DATA, 32'hC3);
		check({24'h0, cap[15:8]}, 32'h5A);
		en <= 1'b0;
		$display("command test done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// pin synchronisers settle before the port runs
		repeat (4) @(posedge clk);
		#1;
		t_reset;
		t_regs;
		t_loop;
		t_ovr;
		t_cmd;
		report_and_stop;
	end
	initial begin
		#(40 * 30000);
		fail_count++;
		report_and_stop;
	end
endmodule
`default_nettype wire
